//--- itest_pkg.sv
// Constants for the interrupt controller integration test registers
package itest_pkg;

   // --------------------
   // Register offsets (byte addresses within each register window)
   // --------------------
   localparam logic [11:0] CPU_TEST_MODE_CTRL_OFS      = 12'h040;
   localparam logic [11:0] CPU_IRQ_LINE_FORCE_OFS      = 12'h044;
   localparam logic [11:0] CPU_SELECT_TIE_STATUS_OFS   = 12'h050;
   localparam logic [11:0] CPU_QUALIFY_TIE_STATUS_OFS  = 12'h054;
   localparam logic [11:0] DIST_LEGACY_LINE_STATUS_OFS = 12'hdd4;
   localparam logic [11:0] DIST_SELECT_TIE_STATUS_OFS  = 12'hde0;
   localparam logic [11:0] DIST_QUALIFY_TIE_STATUS_OFS = 12'hde4;

   // --------------------
   // Field positions
   // --------------------
   localparam int LEGACY_IRQ_BIT   = 0;
   localparam int LEGACY_FIQ_BIT   = 1;
   localparam int SEC_DISABLE_BIT  = 2;
   localparam int TEST_EN_BIT      = 0;
   localparam int FORCE_IRQ_BIT    = 0;
   localparam int FORCE_FIQ_BIT    = 1;
   localparam int PROT_NONSEC_BIT  = 1;
   localparam int ADDR_W           = 12;

   // --------------------
   // Reset values and bus answers
   // --------------------
   localparam logic       TEST_EN_RST   = 1'b0;
   localparam logic       FORCE_RST     = 1'b0;
   localparam logic       LINE_IDLE_RST = 1'b1;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam int         MAX_CPU       = 8;
   localparam int         MAX_ID_WIDTH  = 32;

   // Mask keeping the low width bits of a tie-off bus
   function automatic logic [31:0] width_mask(input int width);
      logic [31:0] m;
      m = '0;
      for (int b = 0; b < 32; b++) begin
         m[b] = (b < width);
      end
      return m;
   endfunction

endpackage

//--- itest_bus_port.sv
// Single-beat register slave on the documented read and write channels
`timescale 1ns/100ps
module itest_bus_port #(
   parameter int ID_W = 4
) (
   input  wire logic            i_sys_clk,
   input  wire logic            i_rst_n,
   input  wire logic [31:0]     i_awaddr,
   input  wire logic [ID_W-1:0] i_awid,
   input  wire logic [2:0]      i_awprot,
   input  wire logic            i_awvalid,
   output logic                 o_awready,
   input  wire logic [31:0]     i_wdata,
   input  wire logic [3:0]      i_wstrb,
   input  wire logic            i_wvalid,
   output logic                 o_wready,
   output logic [ID_W-1:0]      o_bid,
   output logic [1:0]           o_bresp,
   output logic                 o_bvalid,
   input  wire logic            i_bready,
   input  wire logic [31:0]     i_araddr,
   input  wire logic [ID_W-1:0] i_arid,
   input  wire logic [2:0]      i_arprot,
   input  wire logic            i_arvalid,
   output logic                 o_arready,
   output logic [31:0]          o_rdata,
   output logic [ID_W-1:0]      o_rid,
   output logic [1:0]           o_rresp,
   output logic                 o_rlast,
   output logic                 o_rvalid,
   input  wire logic            i_rready,
   output logic                 o_wr_en,
   output logic                 o_rd_en,
   input  wire logic [31:0]     i_rd_data
);
   import itest_pkg::*;

   logic            bvalid_q;
   logic [ID_W-1:0] bid_q;
   logic            rvalid_q;
   logic [ID_W-1:0] rid_q;
   logic [31:0]     rdata_q;

   // --------------------
   // Write: address and data are taken together, one beat at a time
   // --------------------
   assign o_wr_en   = i_awvalid && i_wvalid && !bvalid_q;
   assign o_awready = o_wr_en;
   assign o_wready  = o_wr_en;

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         bvalid_q <= 1'b0;
      end else if (o_wr_en) begin
         bvalid_q <= 1'b1;
      end else if (i_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         bid_q <= '0;
      end else if (o_wr_en) begin
         bid_q <= i_awid;
      end
   end

   assign o_bvalid = bvalid_q;
   assign o_bid    = bid_q;
   assign o_bresp  = RESP_OKAY;

   // --------------------
   // Read: data is sampled in the cycle the address is taken
   // --------------------
   assign o_rd_en   = i_arvalid && !rvalid_q;
   assign o_arready = o_rd_en;

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         rvalid_q <= 1'b0;
      end else if (o_rd_en) begin
         rvalid_q <= 1'b1;
      end else if (i_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         rid_q   <= '0;
         rdata_q <= '0;
      end else if (o_rd_en) begin
         rid_q   <= i_arid;
         rdata_q <= i_rd_data;
      end
   end

   assign o_rvalid = rvalid_q;
   assign o_rlast  = rvalid_q;
   assign o_rid    = rid_q;
   assign o_rdata  = rdata_q;
   assign o_rresp  = RESP_OKAY;

endmodule

//--- itest_regs.sv
// Integration test registers of the distributor and the CPU interfaces
//
// Summary of operation
// - Legacy status returns IRQ input bit0, FIQ input bit1, security-disable bit2.
// - One legacy status register exists per CPU interface, in every configuration.
// - All test registers are reachable only by secure accesses.
// - Distributor select-tie status mirrors inputs; bits at/above distributor ID width read 0.
// - Distributor qualify-tie status mirrors inputs; bits beyond distributor ID width read 0.
// - Select and qualify tie status exist only with two or more interfaces.
// - CPU select-tie status mirrors inputs; bits above CPU ID width read 0.
// - CPU qualify-tie status mirrors inputs; bits above CPU ID width read 0.
// - Test enable 0 leaves IRQ/FIQ functional; 1 lets test logic set IRQ, and FIQ only when SEC_SUPPORT is 1.
// - Force bit0 reads current IRQ output level; a write sets it.
// - Force bit1 handles FIQ only with secure support, else reads 0.
// - Up to eight interfaces, each with its own per-interface test registers.
// - Byte, halfword or word accesses; little-endian data only.
// - Reset is active low, clears test enable and force bits to zero, and sets the IRQ/FIQ output lines high.
`timescale 1ns/100ps
module itest_regs #(
   parameter int   NUM_CPU       = 8,
   parameter int   DIST_ID_WIDTH = 8,
   parameter int   CPU_ID_WIDTH  = 8,
   parameter logic SEC_SUPPORT   = 1'b1
) (
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_rst_n,
   // Distributor register port
   input  wire logic [31:0]                   i_d_awaddr,
   input  wire logic [DIST_ID_WIDTH-1:0]      i_d_awid,
   input  wire logic [2:0]                    i_d_awprot,
   input  wire logic                          i_d_awvalid,
   output logic                               o_d_awready,
   input  wire logic [31:0]                   i_d_wdata,
   input  wire logic [3:0]                    i_d_wstrb,
   input  wire logic                          i_d_wvalid,
   output logic                               o_d_wready,
   output logic [DIST_ID_WIDTH-1:0]           o_d_bid,
   output logic [1:0]                         o_d_bresp,
   output logic                               o_d_bvalid,
   input  wire logic                          i_d_bready,
   input  wire logic [31:0]                   i_d_araddr,
   input  wire logic [DIST_ID_WIDTH-1:0]      i_d_arid,
   input  wire logic [2:0]                    i_d_arprot,
   input  wire logic                          i_d_arvalid,
   output logic                               o_d_arready,
   output logic [31:0]                        o_d_rdata,
   output logic [DIST_ID_WIDTH-1:0]           o_d_rid,
   output logic [1:0]                         o_d_rresp,
   output logic                               o_d_rlast,
   output logic                               o_d_rvalid,
   input  wire logic                          i_d_rready,
   // CPU interface register port
   input  wire logic [31:0]                   i_c_awaddr,
   input  wire logic [CPU_ID_WIDTH-1:0]       i_c_awid,
   input  wire logic [2:0]                    i_c_awprot,
   input  wire logic                          i_c_awvalid,
   output logic                               o_c_awready,
   input  wire logic [31:0]                   i_c_wdata,
   input  wire logic [3:0]                    i_c_wstrb,
   input  wire logic                          i_c_wvalid,
   output logic                               o_c_wready,
   output logic [CPU_ID_WIDTH-1:0]            o_c_bid,
   output logic [1:0]                         o_c_bresp,
   output logic                               o_c_bvalid,
   input  wire logic                          i_c_bready,
   input  wire logic [31:0]                   i_c_araddr,
   input  wire logic [CPU_ID_WIDTH-1:0]       i_c_arid,
   input  wire logic [2:0]                    i_c_arprot,
   input  wire logic                          i_c_arvalid,
   output logic                               o_c_arready,
   output logic [31:0]                        o_c_rdata,
   output logic [CPU_ID_WIDTH-1:0]            o_c_rid,
   output logic [1:0]                         o_c_rresp,
   output logic                               o_c_rlast,
   output logic                               o_c_rvalid,
   input  wire logic                          i_c_rready,
   // Observed lines and tie-offs
   input  wire logic [NUM_CPU-1:0]            i_legacy_irq,
   input  wire logic [NUM_CPU-1:0]            i_legacy_fiq,
   input  wire logic                          i_sec_disable,
   input  wire logic [31:0]                   i_dist_select_tie [NUM_CPU],
   input  wire logic [31:0]                   i_dist_qualify_tie [NUM_CPU],
   input  wire logic [31:0]                   i_cpu_select_tie [NUM_CPU],
   input  wire logic [31:0]                   i_cpu_qualify_tie [NUM_CPU],
   // Functional interrupt line levels and the driven outputs
   input  wire logic [NUM_CPU-1:0]            i_func_irq_n,
   input  wire logic [NUM_CPU-1:0]            i_func_fiq_n,
   output logic [NUM_CPU-1:0]                 o_irq_n,
   output logic [NUM_CPU-1:0]                 o_fiq_n
);
   import itest_pkg::*;

   localparam int          IDX_W      = (NUM_CPU > 1) ? $clog2(NUM_CPU) : 1;
   localparam logic        MULTI_CPU  = (NUM_CPU >= 2);
   localparam logic [31:0] DIST_MASK  = width_mask(DIST_ID_WIDTH);
   localparam logic [31:0] CPU_MASK   = width_mask(CPU_ID_WIDTH);

   logic [31:0]        dsel_m  [NUM_CPU];
   logic [31:0]        dqual_m [NUM_CPU];
   logic [31:0]        csel_m  [NUM_CPU];
   logic [31:0]        cqual_m [NUM_CPU];
   logic [NUM_CPU-1:0] test_en_q;
   logic [NUM_CPU-1:0] force_irq_q;
   logic [NUM_CPU-1:0] force_fiq_q;
   logic [NUM_CPU-1:0] irq_n_q;
   logic [NUM_CPU-1:0] fiq_n_q;
   logic               d_wr_en;
   logic               d_rd_en;
   logic               c_wr_en;
   logic               c_rd_en;
   logic [31:0]        d_rd_data;
   logic [31:0]        c_rd_data;
   logic [IDX_W-1:0]   d_rd_idx;
   logic [IDX_W-1:0]   c_rd_idx;
   logic [IDX_W-1:0]   c_wr_idx;
   logic               c_wr_secure;

   // --------------------
   // Tie-off views, cut to the configured ID width
   // --------------------
   generate
      for (genvar n = 0; n < NUM_CPU; n++) begin : g_tie
         assign dsel_m[n]  = MULTI_CPU ? (i_dist_select_tie[n] & DIST_MASK) : '0;
         assign dqual_m[n] = MULTI_CPU ? (i_dist_qualify_tie[n] & DIST_MASK) : '0;
         assign csel_m[n]  = MULTI_CPU ? (i_cpu_select_tie[n] & CPU_MASK) : '0;
         assign cqual_m[n] = MULTI_CPU ? (i_cpu_qualify_tie[n] & CPU_MASK) : '0;
      end
   endgenerate

   // Lowest interface whose qualified select matches the transaction ID
   function automatic logic [IDX_W-1:0] owner(input logic [31:0] id,
                                              input logic [31:0] sel [NUM_CPU],
                                              input logic [31:0] qual [NUM_CPU]);
      logic [IDX_W-1:0] r;
      r = '0;
      for (int k = NUM_CPU - 1; k >= 0; k--) begin
         if ((id & qual[k]) == (sel[k] & qual[k])) begin
            r = IDX_W'(k);
         end
      end
      return r;
   endfunction

   assign d_rd_idx = owner(32'(i_d_arid), dsel_m, dqual_m);
   assign c_rd_idx = owner(32'(i_c_arid), csel_m, cqual_m);
   assign c_wr_idx = owner(32'(i_c_awid), csel_m, cqual_m);
   assign c_wr_secure = !i_c_awprot[PROT_NONSEC_BIT];

   // --------------------
   // Bus ports
   // --------------------
   itest_bus_port #(.ID_W(DIST_ID_WIDTH)) u_dist_port (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_awaddr  (i_d_awaddr),
      .i_awid    (i_d_awid),
      .i_awprot  (i_d_awprot),
      .i_awvalid (i_d_awvalid),
      .o_awready (o_d_awready),
      .i_wdata   (i_d_wdata),
      .i_wstrb   (i_d_wstrb),
      .i_wvalid  (i_d_wvalid),
      .o_wready  (o_d_wready),
      .o_bid     (o_d_bid),
      .o_bresp   (o_d_bresp),
      .o_bvalid  (o_d_bvalid),
      .i_bready  (i_d_bready),
      .i_araddr  (i_d_araddr),
      .i_arid    (i_d_arid),
      .i_arprot  (i_d_arprot),
      .i_arvalid (i_d_arvalid),
      .o_arready (o_d_arready),
      .o_rdata   (o_d_rdata),
      .o_rid     (o_d_rid),
      .o_rresp   (o_d_rresp),
      .o_rlast   (o_d_rlast),
      .o_rvalid  (o_d_rvalid),
      .i_rready  (i_d_rready),
      .o_wr_en   (d_wr_en),
      .o_rd_en   (d_rd_en),
      .i_rd_data (d_rd_data)
   );

   itest_bus_port #(.ID_W(CPU_ID_WIDTH)) u_cpu_port (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_awaddr  (i_c_awaddr),
      .i_awid    (i_c_awid),
      .i_awprot  (i_c_awprot),
      .i_awvalid (i_c_awvalid),
      .o_awready (o_c_awready),
      .i_wdata   (i_c_wdata),
      .i_wstrb   (i_c_wstrb),
      .i_wvalid  (i_c_wvalid),
      .o_wready  (o_c_wready),
      .o_bid     (o_c_bid),
      .o_bresp   (o_c_bresp),
      .o_bvalid  (o_c_bvalid),
      .i_bready  (i_c_bready),
      .i_araddr  (i_c_araddr),
      .i_arid    (i_c_arid),
      .i_arprot  (i_c_arprot),
      .i_arvalid (i_c_arvalid),
      .o_arready (o_c_arready),
      .o_rdata   (o_c_rdata),
      .o_rid     (o_c_rid),
      .o_rresp   (o_c_rresp),
      .o_rlast   (o_c_rlast),
      .o_rvalid  (o_c_rvalid),
      .i_rready  (i_c_rready),
      .o_wr_en   (c_wr_en),
      .o_rd_en   (c_rd_en),
      .i_rd_data (c_rd_data)
   );

   // --------------------
   // Distributor read data (nothing in this window is writable)
   // --------------------
   always_comb begin
      d_rd_data = '0;
      if (!i_d_arprot[PROT_NONSEC_BIT]) begin
         case (i_d_araddr[ADDR_W-1:2])
            DIST_LEGACY_LINE_STATUS_OFS[ADDR_W-1:2]: begin
               d_rd_data[LEGACY_IRQ_BIT]  = i_legacy_irq[d_rd_idx];
               d_rd_data[LEGACY_FIQ_BIT]  = i_legacy_fiq[d_rd_idx];
               d_rd_data[SEC_DISABLE_BIT] = i_sec_disable;
            end
            DIST_SELECT_TIE_STATUS_OFS[ADDR_W-1:2]: begin
               d_rd_data = dsel_m[d_rd_idx];
            end
            DIST_QUALIFY_TIE_STATUS_OFS[ADDR_W-1:2]: begin
               d_rd_data = dqual_m[d_rd_idx];
            end
            default: begin
               d_rd_data = '0;
            end
         endcase
      end
   end

   // --------------------
   // CPU interface read data
   // --------------------
   always_comb begin
      c_rd_data = '0;
      if (!i_c_arprot[PROT_NONSEC_BIT]) begin
         case (i_c_araddr[ADDR_W-1:2])
            CPU_TEST_MODE_CTRL_OFS[ADDR_W-1:2]: begin
               c_rd_data[TEST_EN_BIT] = test_en_q[c_rd_idx];
            end
            CPU_IRQ_LINE_FORCE_OFS[ADDR_W-1:2]: begin
               c_rd_data[FORCE_IRQ_BIT] = irq_n_q[c_rd_idx];
               c_rd_data[FORCE_FIQ_BIT] = SEC_SUPPORT && fiq_n_q[c_rd_idx];
            end
            CPU_SELECT_TIE_STATUS_OFS[ADDR_W-1:2]: begin
               c_rd_data = csel_m[c_rd_idx];
            end
            CPU_QUALIFY_TIE_STATUS_OFS[ADDR_W-1:2]: begin
               c_rd_data = cqual_m[c_rd_idx];
            end
            default: begin
               c_rd_data = '0;
            end
         endcase
      end
   end

   // --------------------
   // Per-interface test enable, force and output lines
   // --------------------
   generate
      for (genvar n = 0; n < NUM_CPU; n++) begin : g_cpu
         logic wr_hit;
         // Only byte lane 0 carries live bits
         assign wr_hit = c_wr_en && c_wr_secure && i_c_wstrb[0]
                         && (c_wr_idx == IDX_W'(n));

         always_ff @(posedge i_sys_clk) begin
            if (!i_rst_n) begin
               test_en_q[n] <= TEST_EN_RST;
            end else if (wr_hit &&
                         i_c_awaddr[ADDR_W-1:2] == CPU_TEST_MODE_CTRL_OFS[ADDR_W-1:2]) begin
               test_en_q[n] <= i_c_wdata[TEST_EN_BIT];
            end
         end

         always_ff @(posedge i_sys_clk) begin
            if (!i_rst_n) begin
               force_irq_q[n] <= FORCE_RST;
               force_fiq_q[n] <= FORCE_RST;
            end else if (wr_hit &&
                         i_c_awaddr[ADDR_W-1:2] == CPU_IRQ_LINE_FORCE_OFS[ADDR_W-1:2]) begin
               force_irq_q[n] <= i_c_wdata[FORCE_IRQ_BIT];
               force_fiq_q[n] <= SEC_SUPPORT && i_c_wdata[FORCE_FIQ_BIT];
            end
         end

         // Output lines idle high; functional levels pass unless test enabled, and FIQ passes always when SEC_SUPPORT is 0
         always_ff @(posedge i_sys_clk) begin
            if (!i_rst_n) begin
               irq_n_q[n] <= LINE_IDLE_RST;
               fiq_n_q[n] <= LINE_IDLE_RST;
            end else if (test_en_q[n]) begin
               irq_n_q[n] <= force_irq_q[n];
               fiq_n_q[n] <= SEC_SUPPORT ? force_fiq_q[n] : i_func_fiq_n[n];
            end else begin
               irq_n_q[n] <= i_func_irq_n[n];
               fiq_n_q[n] <= i_func_fiq_n[n];
            end
         end
      end
   endgenerate

   assign o_irq_n = irq_n_q;
   assign o_fiq_n = fiq_n_q;

endmodule

//--- itest_regs_monitor.sv
// Concurrent checks on the integration test register ports
`timescale 1ns/100ps
module itest_regs_monitor
   import itest_pkg::*;
#(
   parameter int NUM_CPU      = 8,
   parameter int CPU_ID_WIDTH = 8
) (
   input logic                    i_sys_clk, i_rst_n, i_sec_disable,
   input logic                    i_c_awvalid, i_c_wvalid, i_c_bready, i_c_arvalid, i_d_arvalid,
   input logic                    o_c_bvalid, o_c_rvalid, o_c_rlast, o_d_rvalid,
   input logic [CPU_ID_WIDTH-1:0] o_c_bid,
   input logic [2:0]              i_c_arprot, i_d_arprot,
   input logic [1:0]              o_c_bresp, o_c_rresp,
   input logic [31:0]             i_d_araddr, o_c_rdata, o_d_rdata,
   input logic [NUM_CPU-1:0]      o_irq_n, o_fiq_n
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_c_wr_take; i_c_awvalid && i_c_wvalid && !o_c_bvalid; endsequence
   sequence s_c_rd_take; i_c_arvalid && !o_c_rvalid; endsequence
   sequence s_d_rd_take; i_d_arvalid && !o_d_rvalid && !i_d_arprot[PROT_NONSEC_BIT]; endsequence
   property p_c_wr_ans; s_c_wr_take |=> o_c_bvalid; endproperty
   property p_c_b_hold; o_c_bvalid && !i_c_bready |=> o_c_bvalid && $stable(o_c_bid); endproperty
   property p_c_rd_ans; s_c_rd_take |=> o_c_rvalid && o_c_rlast; endproperty
   property p_c_nonsec_rd;
      s_c_rd_take ##0 i_c_arprot[PROT_NONSEC_BIT] |=> o_c_rdata == 32'h0;
   endproperty
   property p_d_rd_ans; s_d_rd_take |=> o_d_rvalid; endproperty
   property p_d_legacy;
      s_d_rd_take ##0 i_d_araddr[11:0] == DIST_LEGACY_LINE_STATUS_OFS |=>
         o_d_rdata[31:3] == 29'h0 && o_d_rdata[SEC_DISABLE_BIT] == $past(i_sec_disable);
   endproperty
   property p_resp_ok;
      o_c_bvalid || o_c_rvalid |-> o_c_bresp == RESP_OKAY && o_c_rresp == RESP_OKAY;
   endproperty
   property p_rst_lines; $rose(i_rst_n) |-> &o_irq_n && &o_fiq_n; endproperty
   a_c_wr_ans: assert property (p_c_wr_ans) else $error("write not answered");
   a_c_b_hold: assert property (p_c_b_hold) else $error("write answer dropped");
   a_c_rd_ans: assert property (p_c_rd_ans) else $error("read not answered");
   a_c_nonsec_rd: assert property (p_c_nonsec_rd) else $error("open read data");
   a_d_rd_ans: assert property (p_d_rd_ans) else $error("secure read lost");
   a_d_legacy: assert property (p_d_legacy) else $error("legacy status wrong");
   a_resp_ok: assert property (p_resp_ok) else $error("response not okay");
   a_rst_lines: assert property (p_rst_lines) else $error("lines not idle");
endmodule

//--- itest_bus_master.sv
// Bus master model issuing single-beat register accesses on either port
`timescale 1ns/100ps
module itest_bus_master #(
   parameter int DW = 4,
   parameter int CW = 6
) (
   input  logic          i_sys_clk, o_d_awready, o_d_arready, o_d_bvalid, o_d_rvalid,
   input  logic          o_c_awready, o_c_arready, o_c_bvalid, o_c_rvalid,
   input  logic [31:0]   o_d_rdata, o_c_rdata,
   output logic [31:0]   i_d_awaddr, i_d_araddr, i_d_wdata, i_c_awaddr, i_c_araddr, i_c_wdata,
   output logic [2:0]    i_d_awprot, i_d_arprot, i_c_awprot, i_c_arprot,
   output logic [3:0]    i_d_wstrb, i_c_wstrb,
   output logic [DW-1:0] i_d_awid, i_d_arid,
   output logic [CW-1:0] i_c_awid, i_c_arid,
   output logic          i_d_awvalid, i_d_wvalid, i_d_bready, i_d_arvalid, i_d_rready,
   output logic          i_c_awvalid, i_c_wvalid, i_c_bready, i_c_arvalid, i_c_rready,
   output logic          o_hang
);
   logic [31:0] a, d;
   logic [7:0]  id;
   logic [3:0]  s;
   logic [2:0]  p;
   logic        c, wv, rv, rr, slow;
   wire rdy = c ? (wv ? o_c_awready : o_c_arready) : (wv ? o_d_awready : o_d_arready);
   wire rsp = c ? (o_c_bvalid | o_c_rvalid) : (o_d_bvalid | o_d_rvalid);
   assign i_d_awaddr = a, i_d_araddr = a, i_c_awaddr = a, i_c_araddr = a;
   assign i_d_wdata = d, i_c_wdata = d, i_d_wstrb = s, i_c_wstrb = s;
   assign i_d_awprot = p, i_d_arprot = p, i_c_awprot = p, i_c_arprot = p;
   assign i_d_awid = id[DW-1:0], i_d_arid = id[DW-1:0];
   assign i_c_awid = id[CW-1:0], i_c_arid = id[CW-1:0];
   assign i_d_awvalid = wv & !c, i_d_wvalid = wv & !c, i_d_arvalid = rv & !c;
   assign i_c_awvalid = wv & c, i_c_wvalid = wv & c, i_c_arvalid = rv & c;
   assign i_d_bready = rr, i_d_rready = rr, i_c_bready = rr, i_c_rready = rr;
   initial begin
      {c, wv, rv, rr, slow, o_hang} = '0;
      {a, d, id, s, p} = '0;
   end
   // Slow mode holds the answer off for two edges before accepting it
   task automatic xfer(input logic pc, w, input logic [31:0] pa, pd, input logic [2:0] pp,
                       input logic [3:0] ps, input logic [7:0] pi, output logic [31:0] q);
      int k;
      int j;
      @(posedge i_sys_clk);
      c <= pc; a <= pa; d <= pd; p <= pp; s <= ps; id <= pi; wv <= w; rv <= !w; rr <= !slow;
      // Ready and answer are looked at mid-cycle, where they have settled
      @(negedge i_sys_clk);
      for (k = 0; !rdy && k < 50; k++) @(negedge i_sys_clk);
      @(posedge i_sys_clk);
      // Released lines must not keep showing the old address or data
      wv <= 1'b0; rv <= 1'b0; a <= ~pa; d <= ~pd;
      @(negedge i_sys_clk);
      for (j = 0; !(rsp && rr) && j < 50; j++) begin
         @(posedge i_sys_clk);
         if (j == 1) rr <= 1'b1;
         @(negedge i_sys_clk);
      end
      q = c ? o_c_rdata : o_d_rdata;
      @(posedge i_sys_clk);
      if (k >= 50 || j >= 50) o_hang <= 1'b1;
   endtask
endmodule

//--- itest_regs_tb_top.sv
// Self-checking testbench for the integration test registers
`timescale 1ns/100ps
module itest_regs_tb_top;
   import itest_pkg::*;
   localparam int NC = 2, DW = 4, CW = 6;
   logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_sec_disable = 1'b0, o_hang;
   logic i_d_awvalid, i_d_wvalid, i_d_bready, i_d_arvalid, i_d_rready, o_d_awready, o_d_wready;
   logic o_d_bvalid, o_d_arready, o_d_rlast, o_d_rvalid, o_c_awready, o_c_wready, o_c_bvalid;
   logic i_c_awvalid, i_c_wvalid, i_c_bready, i_c_arvalid, i_c_rready;
   logic o_c_arready, o_c_rlast, o_c_rvalid;
   logic [31:0] i_d_awaddr, i_d_wdata, i_d_araddr, o_d_rdata;
   logic [31:0] i_c_awaddr, i_c_wdata, i_c_araddr, o_c_rdata;
   logic [2:0] i_d_awprot, i_d_arprot, i_c_awprot, i_c_arprot;
   logic [3:0] i_d_wstrb, i_c_wstrb;
   logic [1:0] o_d_bresp, o_d_rresp, o_c_bresp, o_c_rresp;
   logic [DW-1:0] i_d_awid, i_d_arid, o_d_bid, o_d_rid;
   logic [CW-1:0] i_c_awid, i_c_arid, o_c_bid, o_c_rid;
   logic [NC-1:0] i_legacy_irq, i_legacy_fiq, i_func_irq_n, i_func_fiq_n, o_irq_n, o_fiq_n;
   logic [31:0] i_dist_select_tie [NC], i_dist_qualify_tie [NC];
   logic [31:0] i_cpu_select_tie [NC], i_cpu_qualify_tie [NC];
   int errors = 0, check_count = 0;
   always #4 i_sys_clk = ~i_sys_clk;
   itest_regs #(.NUM_CPU(NC), .DIST_ID_WIDTH(DW), .CPU_ID_WIDTH(CW), .SEC_SUPPORT(1'b1)) dut (.*);
   itest_bus_master #(.DW(DW), .CW(CW)) m (.*);
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic c, input logic [11:0] o, input logic [7:0] i, input logic ns,
                     input logic [31:0] v, input logic [3:0] st);
      logic [31:0] q;
      m.xfer(c, 1'b1, {20'h0, o}, v, {1'b0, ns, 1'b0}, st, i, q);
   endtask
   task automatic rdc(input logic c, input logic [11:0] o, input logic [7:0] i, input logic ns,
                      input logic [31:0] e);
      logic [31:0] q;
      m.xfer(c, 1'b0, {20'h0, o}, 32'h0, {1'b0, ns, 1'b0}, 4'hf, i, q);
      chk(q, e);
   endtask
   task automatic t_reset;
      chk({o_fiq_n, o_irq_n}, 32'hf);
      for (int n = 0; n < NC; n++) begin
         rdc(1, CPU_TEST_MODE_CTRL_OFS, 8'(n), 0, 32'h0);
         rdc(1, CPU_IRQ_LINE_FORCE_OFS, 8'(n), 0, 32'h3);
      end
   endtask
   task automatic t_legacy;
      logic [NC-1:0] oh;
      for (int n = 0; n < NC; n++) begin
         oh = NC'(1) << n;
         for (int v = 0; v < 8; v++) begin
            @(posedge i_sys_clk);
            i_legacy_irq <= v[0] ? oh : ~oh;
            i_legacy_fiq <= v[1] ? oh : ~oh;
            i_sec_disable <= v[2];
            rdc(0, DIST_LEGACY_LINE_STATUS_OFS, 8'(n), 0, 32'(v));
         end
         wr(0, DIST_LEGACY_LINE_STATUS_OFS, 8'(n), 0, 32'h0, 4'hf);
         rdc(0, DIST_LEGACY_LINE_STATUS_OFS, 8'(n), 0, 32'h7);
      end
   endtask
   task automatic t_ties;
      for (int n = 0; n < NC; n++) begin
         rdc(0, DIST_SELECT_TIE_STATUS_OFS, 8'(n), 0, 32'(n));
         rdc(0, DIST_QUALIFY_TIE_STATUS_OFS, 8'(n), 0, 32'hf);
         rdc(1, CPU_SELECT_TIE_STATUS_OFS, 8'(n), 0, 32'(n));
         rdc(1, CPU_QUALIFY_TIE_STATUS_OFS, 8'(n), 0, 32'h3f);
      end
   endtask
   task automatic t_force(input int n);
      logic [7:0] i;
      i = 8'(n);
      wr(1, CPU_TEST_MODE_CTRL_OFS, i, 0, 32'h1, 4'hf);
      for (int v = 0; v < 4; v++) begin
         wr(1, CPU_IRQ_LINE_FORCE_OFS, i, 0, 32'(v), 4'hf);
         repeat (2) @(posedge i_sys_clk);
         chk({o_fiq_n[n], o_irq_n[n]}, 32'(v));
         chk({o_fiq_n[1-n], o_irq_n[1-n]}, 32'h3);
         rdc(1, CPU_IRQ_LINE_FORCE_OFS, i, 0, 32'(v));
      end
      m.slow = 1'b1;
      wr(1, CPU_IRQ_LINE_FORCE_OFS, i, 0, 32'h0, 4'he);
      wr(1, CPU_IRQ_LINE_FORCE_OFS, i, 1, 32'h0, 4'hf);
      rdc(1, CPU_IRQ_LINE_FORCE_OFS, i, 0, 32'h3);
      rdc(1, CPU_IRQ_LINE_FORCE_OFS, i, 1, 32'h0);
      rdc(1, 12'h048, i, 0, 32'h0);
      m.slow = 1'b0;
      wr(1, CPU_TEST_MODE_CTRL_OFS, i, 1, 32'h0, 4'hf);
      @(posedge i_sys_clk);
      i_func_irq_n <= ~(NC'(1) << n);
      repeat (2) @(posedge i_sys_clk);
      chk({o_fiq_n[n], o_irq_n[n]}, 32'h3);
      wr(1, CPU_TEST_MODE_CTRL_OFS, i, 0, 32'h0, 4'hf);
      repeat (2) @(posedge i_sys_clk);
      chk({o_fiq_n[n], o_irq_n[n]}, 32'h2);
      i_func_irq_n <= '1;
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge o_hang) begin
      errors++;
      end_of_test;
   end
   initial begin
      {i_legacy_irq, i_legacy_fiq} = '0;
      {i_func_irq_n, i_func_fiq_n} = '1;
      for (int n = 0; n < NC; n++) begin
         i_cpu_select_tie[n] = 32'habcd_ef00 | 32'(n);
         i_cpu_qualify_tie[n] = 32'hffff_ffff;
         i_dist_select_tie[n] = 32'h5a5a_5a50 | 32'(n);
         i_dist_qualify_tie[n] = 32'h1234_567f;
      end
      repeat (2) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      t_reset;
      t_legacy;
      t_ties;
      t_force(0);
      t_force(1);
      end_of_test;
   end
endmodule
bind itest_regs itest_regs_monitor #(.NUM_CPU(NUM_CPU), .CPU_ID_WIDTH(CPU_ID_WIDTH)) u_mon (.*);
